// [verilog/tgpc_pkg.sv]
package tgpc_pkg;

  localparam int          TGPC_PINS       = 7;
  localparam int          TGPC_ADDR_W     = 6;
  localparam int          TGPC_DATA_W     = 16;
  localparam logic [5:0]  DIR_ADDR        = 6'h0b;
  localparam logic [5:0]  OUTVAL_ADDR     = 6'h0c;
  localparam logic [5:0]  CTRLC_ADDR      = 6'h09;

  localparam int          DIR_DRV_HI      = 15;
  localparam int          DIR_DRV_LO      = 14;
  localparam int          DIR_OEN_HI      = 13;
  localparam int          DIR_OEN_LO      = 7;
  localparam int          DIR_IEN_HI      = 6;
  localparam int          DIR_IEN_LO      = 0;
  localparam int          OV_HDRV_LO      = 14;
  localparam int          OV_MISO_LO      = 12;
  localparam int          OV_CLKO_LO      = 10;
  localparam int          OV_IRQ_LO       = 8;
  localparam int          OV_PUP_BIT      = 7;
  localparam int          OV_LVL_LO       = 0;
  localparam int          CTRLC_ALT_BIT   = 7;

  localparam logic [15:0] DIR_RESET       = 16'h0000;
  localparam logic [15:0] OUTVAL_RESET    = 16'h0380;
  localparam logic [15:0] CTRLC_RESET     = 16'h0000;

  typedef struct packed {
    logic        wrEn;
    logic        rdEn;
    logic [5:0]  addr;
    logic [15:0] wrData;
  } tgpc_req_t;

  typedef struct packed {
    logic [1:0] lowPinsDrive;
    logic [1:0] highPinsDrive;
    logic [1:0] misoDrive;
    logic [1:0] clkoDrive;
    logic [1:0] irqDrive;
    logic       irqPullupEn;
  } tgpc_drive_t;

  typedef enum logic [1:0] {
    TGPC_PIN_FLOAT  = 2'b00,
    TGPC_PIN_INPUT  = 2'b01,
    TGPC_PIN_OUTPUT = 2'b11
  } tgpc_pinmode_t;

  function automatic tgpc_pinmode_t tgpc_pin_mode(input logic ien, input logic oen);
    if (ien)
    begin
      return TGPC_PIN_INPUT;
    end
    else if (oen)
    begin
      return TGPC_PIN_OUTPUT;
    end
    return TGPC_PIN_FLOAT;
  endfunction : tgpc_pin_mode

endpackage : tgpc_pkg

// [verilog/tgpc_reg16.sv]
`timescale 1ns/100ps
module tgpc_reg16
  import tgpc_pkg::*;
#(
  parameter logic [15:0] RESET_VALUE = 16'h0000
)
(
  input  wire logic        clock,
  input  wire logic        resetn,
  input  wire logic        load,
  input  wire logic [15:0] loadData,
  output logic      [15:0] value
);

  typedef struct packed {
    logic [15:0] value;
  } tgpc_r16_state_t;

  tgpc_r16_state_t state_q;
  tgpc_r16_state_t state_d;

  always_comb
  begin
    state_d = state_q;
    if (load)
    begin
      state_d.value = loadData;
    end
  end

  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      state_q <= '{value: RESET_VALUE};
    end
    else
    begin
      state_q <= state_d;
    end
  end

  assign value = state_q.value;

endmodule : tgpc_reg16

// [verilog/tgpc_pin_ctrl.sv]
`timescale 1ns/100ps
module tgpc_pin_ctrl
  import tgpc_pkg::*;
(
  input  wire logic ien,
  input  wire logic oen,
  input  wire logic level,
  input  wire logic altEn,
  input  wire logic altLevel,
  output logic      padOut,
  output logic      padOe_n
);

  tgpc_pinmode_t mode;

  always_comb
  begin
    mode    = tgpc_pin_mode(ien, oen);
    padOut  = 1'b0;
    padOe_n = 1'b1;
    if (altEn)
    begin
      padOut  = altLevel;
      padOe_n = 1'b0;
    end
    else if (mode == TGPC_PIN_OUTPUT)
    begin
      padOut  = level;
      padOe_n = 1'b0;
    end
    else
    begin
      padOe_n = 1'b1;
    end
  end

endmodule : tgpc_pin_ctrl

// [verilog/tgpc_pad_control.sv]
// Notes on behaviour
// - direction bits 13..7 enable output drivers of pins 7..1
// - direction bits 6..0 enable inputs of pins 7..1
// - both enables set: pin is an input, driver off
// - during reset all pins float and return to input configuration
// - direction bits 15-14 set shared drive of pins 1-4, reset 00
// - output-value bits 15-14 set shared drive of pins 5-7, reset 00
// - output-value bits 13-12 set serial data-out drive, reset 00
// - output-value bits 11-10 set clock-out drive, reset 00
// - output-value bits 9-8 set interrupt pin drive, reset 11
// - output-value bits 6..0 give levels of pins 7..1 when outputs
// - alternate-status enable: pin 1 shows busy, pin 2 checksum/assessment result
`timescale 1ns/100ps
module tgpc_pad_control
  import tgpc_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        resetn,
  input  tgpc_req_t        regReq,
  output logic      [15:0] regRdData,
  input  wire logic        outOfIdle,
  input  wire logic        crcOrCcaValid,
  input  wire logic [6:0]  pinIn,
  output logic      [6:0]  pinOut,
  output logic      [6:0]  pinOe_n,
  output logic      [6:0]  pinInEnable,
  output logic      [6:0]  pinInValue,
  output tgpc_drive_t      padDrive
);

  typedef struct packed {
    logic [15:0] rdData;
    logic [6:0]  inValue;
  } tgpc_top_state_t;

  tgpc_top_state_t state_q;
  tgpc_top_state_t state_d;

  logic [15:0] dirReg;
  logic [15:0] outValReg;
  logic [15:0] ctrlCReg;
  logic        dirLoad;
  logic        outValLoad;
  logic        ctrlCLoad;
  logic [6:0]  oenBits;
  logic [6:0]  ienBits;
  logic [6:0]  lvlBits;
  logic        altEn;
  logic [6:0]  altMask;
  logic [6:0]  altLevel;

  assign dirLoad    = regReq.wrEn && (regReq.addr == DIR_ADDR);
  assign outValLoad = regReq.wrEn && (regReq.addr == OUTVAL_ADDR);
  assign ctrlCLoad  = regReq.wrEn && (regReq.addr == CTRLC_ADDR);

  tgpc_reg16 #(
    .RESET_VALUE (DIR_RESET)
  ) u_dir (
    .clock    (clock),
    .resetn   (resetn),
    .load     (dirLoad),
    .loadData (regReq.wrData),
    .value    (dirReg)
  );

  tgpc_reg16 #(
    .RESET_VALUE (OUTVAL_RESET)
  ) u_outval (
    .clock    (clock),
    .resetn   (resetn),
    .load     (outValLoad),
    .loadData (regReq.wrData),
    .value    (outValReg)
  );

  // only the alternate-status bit is kept
  tgpc_reg16 #(
    .RESET_VALUE (CTRLC_RESET)
  ) u_ctrlc (
    .clock    (clock),
    .resetn   (resetn),
    .load     (ctrlCLoad),
    .loadData (regReq.wrData & (16'h0001 << CTRLC_ALT_BIT)),
    .value    (ctrlCReg)
  );

  assign oenBits = dirReg[DIR_OEN_HI:DIR_OEN_LO];
  assign ienBits = dirReg[DIR_IEN_HI:DIR_IEN_LO];
  assign lvlBits = outValReg[OV_LVL_LO +: TGPC_PINS];
  assign altEn   = ctrlCReg[CTRLC_ALT_BIT];
  assign altMask = {5'b0_0000, altEn, altEn};
  assign altLevel = {5'b0_0000, crcOrCcaValid, outOfIdle};

  // reset values give floating pins with inputs enabled
  genvar gi;
  generate
    for (gi = 0; gi < TGPC_PINS; gi++)
    begin : g_pin
      tgpc_pin_ctrl u_pin (
        .ien      (ienBits[gi]),
        .oen      (oenBits[gi]),
        .level    (lvlBits[gi]),
        .altEn    (altMask[gi]),
        .altLevel (altLevel[gi]),
        .padOut   (pinOut[gi]),
        .padOe_n  (pinOe_n[gi])
      );
    end
  endgenerate

  // during reset the registers hold zero enables: all drivers off
  assign pinInEnable = ienBits | ~(oenBits | altMask);

  always_comb
  begin
    state_d         = state_q;
    state_d.inValue = pinIn & pinInEnable;
    if (regReq.rdEn)
    begin
      unique case (regReq.addr)
        DIR_ADDR:    state_d.rdData = dirReg;
        OUTVAL_ADDR: state_d.rdData = outValReg;
        CTRLC_ADDR:  state_d.rdData = ctrlCReg;
        default:     state_d.rdData = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      state_q <= '{rdData: 16'h0000, inValue: 7'h00};
    end
    else
    begin
      state_q <= state_d;
    end
  end

  assign regRdData  = state_q.rdData;
  assign pinInValue = state_q.inValue;

  // one driver for the whole drive struct
  assign padDrive = '{
    lowPinsDrive:  dirReg[DIR_DRV_HI:DIR_DRV_LO],
    highPinsDrive: outValReg[OV_HDRV_LO +: 2],
    misoDrive:     outValReg[OV_MISO_LO +: 2],
    clkoDrive:     outValReg[OV_CLKO_LO +: 2],
    irqDrive:      outValReg[OV_IRQ_LO +: 2],
    irqPullupEn:   outValReg[OV_PUP_BIT]
  };

endmodule : tgpc_pad_control

// [test/tgpc_board_model.sv]
`timescale 1ns/100ps
module tgpc_board_model
  import tgpc_pkg::*;
(
  input  wire logic [6:0] pinOut,
  input  wire logic [6:0] pinOe_n,
  input  wire logic [6:0] extLevel,
  output logic      [6:0] pinIn
);
  // board drives only pins the device has let go
  assign pinIn = (pinOut & ~pinOe_n) | (extLevel & pinOe_n);
endmodule : tgpc_board_model

// [test/tgpc_pad_control_checker.sv]
`timescale 1ns/100ps
module tgpc_pad_control_checker
  import tgpc_pkg::*;
(
  input wire logic        clock,
  input wire logic        resetn,
  input tgpc_req_t        regReq,
  input wire logic [15:0] regRdData,
  input wire logic        outOfIdle,
  input wire logic        crcOrCcaValid,
  input wire logic [6:0]  pinOut,
  input wire logic [6:0]  pinOe_n,
  input wire logic [6:0]  pinInEnable,
  input tgpc_drive_t      padDrive
);
  logic [15:0] w_q;
  wire         dirW = regReq.wrEn && regReq.addr == DIR_ADDR;
  wire         ovW  = regReq.wrEn && regReq.addr == OUTVAL_ADDR;
  wire         altW = regReq.wrEn && regReq.addr == CTRLC_ADDR && regReq.wrData[7];
  always_ff @(posedge clock) w_q <= regReq.wrData;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!resetn);
  chk_reset_float: assert property (disable iff (1'b0) !resetn |-> pinOe_n == 7'h7f && pinInEnable == 7'h7f)
    else $error("pins not floating");
  chk_dir_drivers: assert property (dirW |=> pinOe_n[6:2] == ~(w_q[13:9] & ~w_q[6:2]))
    else $error("bad output enables");
  chk_dir_inputs: assert property (dirW |=> pinInEnable[6:2] == (w_q[6:2] | ~w_q[13:9]))
    else $error("bad input enables");
  chk_low_drive: assert property (dirW |=> padDrive.lowPinsDrive == w_q[15:14])
    else $error("bad low drive");
  chk_pad_drive: assert property (ovW |=> padDrive[8:0] == w_q[15:7])
    else $error("bad pad drive");
  chk_pin_level: assert property (ovW |=> (pinOut[6:2] | pinOe_n[6:2]) == (w_q[6:2] | pinOe_n[6:2]))
    else $error("bad pin level");
  chk_alt_status: assert property (altW |=> pinOe_n[1:0] == 2'h0 && pinOut[1:0] == {crcOrCcaValid, outOfIdle})
    else $error("bad alt status");
  chk_read_hold: assert property (!regReq.rdEn |=> $stable(regRdData))
    else $error("read data moved");
  cover property (dirW);
  cover property (ovW);
  cover property (altW);
endmodule : tgpc_pad_control_checker

bind tgpc_pad_control tgpc_pad_control_checker u_chk (.clock(clock), .resetn(resetn), .regReq(regReq),
  .regRdData(regRdData), .outOfIdle(outOfIdle), .crcOrCcaValid(crcOrCcaValid), .pinOut(pinOut),
  .pinOe_n(pinOe_n), .pinInEnable(pinInEnable), .padDrive(padDrive));

// [test/tgpc_pad_control_tb.sv]
`timescale 1ns/100ps
module tgpc_pad_control_tb
  import tgpc_pkg::*;
();
  logic        clock;
  logic        resetn;
  logic        outOfIdle;
  logic        crcOrCcaValid;
  tgpc_req_t   regReq;
  tgpc_drive_t padDrive;
  logic [15:0] regRdData;
  logic [6:0]  pinIn, pinOut, pinOe_n, pinInEnable, pinInValue, extLevel;
  int          err_total, num_checks, cycles;

  tgpc_pad_control u_dut (.clock(clock), .resetn(resetn), .regReq(regReq), .regRdData(regRdData),
    .outOfIdle(outOfIdle), .crcOrCcaValid(crcOrCcaValid), .pinIn(pinIn), .pinOut(pinOut),
    .pinOe_n(pinOe_n), .pinInEnable(pinInEnable), .pinInValue(pinInValue), .padDrive(padDrive));
  tgpc_board_model u_board (.pinOut(pinOut), .pinOe_n(pinOe_n), .extLevel(extLevel), .pinIn(pinIn));

  initial
  begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      err_total++;
      summarize();
    end
  end

  task automatic summarize;
    if (err_total == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : summarize

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    @(negedge clock);
    regReq = '{wrEn: 1'b1, rdEn: 1'b0, addr: a, wrData: d};
    @(negedge clock);
    regReq.wrEn = 1'b0;
  endtask : wr

  task automatic rd(input string what, input logic [5:0] a, input logic [15:0] exp);
    @(negedge clock);
    regReq = '{wrEn: 1'b0, rdEn: 1'b1, addr: a, wrData: 16'h0000};
    @(negedge clock);
    regReq.rdEn = 1'b0;
    check(what, regRdData, exp);
  endtask : rd

  task automatic t_reset;
    resetn = 1'b0;
    repeat (2) @(negedge clock);
    check("oe rst", pinOe_n, 7'h7f);
    check("ien rst", pinInEnable, 7'h7f);
    resetn = 1'b1;
    check("drv rst", padDrive, 11'h007);
    rd("dir rst", DIR_ADDR, 16'h0000);
    rd("ov rst", OUTVAL_ADDR, 16'h0380);
  endtask : t_reset

  task automatic t_modes;
    extLevel = 7'h7f;
    wr(DIR_ADDR, 16'hffc0);
    check("oe mix", pinOe_n, 7'h40);
    check("ien mix", pinInEnable, 7'h40);
    check("low drv", padDrive.lowPinsDrive, 2'h3);
    wr(OUTVAL_ADDR, 16'h552a);
    check("levels", pinOut & ~pinOe_n, 7'h2a);
    check("pad drv", padDrive, 11'h06aa);
    check("in val", pinInValue, 7'h40);
    rd("ov back", OUTVAL_ADDR, 16'h552a);
    wr(DIR_ADDR, 16'h0000);
    check("oe idle", pinOe_n, 7'h7f);
  endtask : t_modes

  task automatic t_alt;
    outOfIdle = 1'b1;
    wr(CTRLC_ADDR, 16'hffff);
    check("alt oe", pinOe_n[1:0], 2'h0);
    check("alt lvl", pinOut[1:0], 2'h1);
    outOfIdle = 1'b0;
    crcOrCcaValid = 1'b1;
    #1;
    check("alt flw", pinOut[1:0], 2'h2);
    rd("alt reg", CTRLC_ADDR, 16'h0080);
    wr(CTRLC_ADDR, 16'h0000);
    check("alt off", pinOe_n[1:0], 2'h3);
    wr(6'h3f, 16'hffff);
    rd("unmapped", 6'h3f, 16'h0000);
    rd("dir kept", DIR_ADDR, 16'h0000);
  endtask : t_alt

  initial
  begin
    resetn = 1'b0;
    regReq = '0;
    outOfIdle = 1'b0;
    crcOrCcaValid = 1'b0;
    extLevel = 7'h00;
    t_reset();
    t_modes();
    t_alt();
    wr(OUTVAL_ADDR, 16'h0000);
    t_reset();
    summarize();
  end
endmodule : tgpc_pad_control_tb
